// ### intc_host_port.sv
`timescale 1ns/10ps
// Functional notes
// RULE1 - Data port drives only during selected reads or acknowledge bytes, else floats
// RULE2 - Strobes count only with chip select low; acknowledge ignores chip select
// RULE3 - Mask bit set blocks that request input; mask is readable
// RULE4 - Pending register bit n mirrors request input n; readable
// RULE5 - In-service bit n set while level n is being serviced; readable
// RULE6 - Init and command words stored but never readable
// RULE7 - Winner chosen from mask, in-service state and mode; the code uses pending, mask and in-service state only
// RULE8 - Address 0 read gives pending or in-service by mode word; address 1 gives mask
// RULE9 - Polling phase: address 0 read returns polling data
// RULE10 - Address 0 write: bit four first init word, else bit three picks word
// RULE11 - Address 1 write loads init words two to four, later the mask
// RULE12 - Read and write strobes together do nothing
// RULE13 - Master drives cascade address; slave compares it with its number
// RULE14 - Acknowledge sends call opcode plus address, or one vector byte
// RULE15 - Any write pulls interrupt output low while write strobe low
// RULE16 - Processor gives three acknowledge pulses in call mode, two in vector
module intc_host_port
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Processor bus
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_addr0,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  // Interrupt handshake
  input  wire logic       i_irq_acknowledge_n,
  output logic            o_int,
  // Requests
  input  wire logic [7:0] i_request_inputs,
  // Cascade
  input  wire logic       i_slave_n,
  input  wire logic [2:0] i_cascade_addr,
  output logic      [2:0] o_cascade_addr,
  output logic            o_cascade_addr_oe
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic rd_act;
  logic wr_act;
  logic ack_act;
  logic wr_start;
  logic rd_end;
  logic ack_start;
  logic ack_end;

  assign rd_act  = ~i_cs_n & ~i_rd_n & i_wr_n; // [RULE2] [RULE12]
  assign wr_act  = ~i_cs_n & ~i_wr_n & i_rd_n; // [RULE2] [RULE12]
  assign ack_act = ~i_irq_acknowledge_n;        // [RULE2]

  edge_detect u_wr_edge (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_sig     (wr_act),
    .o_rise    (wr_start),
    .o_fall    ()
  );

  edge_detect u_rd_edge (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_sig     (rd_act),
    .o_rise    (),
    .o_fall    (rd_end)
  );

  edge_detect u_ack_edge (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_sig     (ack_act),
    .o_rise    (ack_start),
    .o_fall    (ack_end)
  );

  // ****************************************
  // Stored words
  // ****************************************
  init_state_e init_q;
  logic [7:0]  iw1_q;
  logic [7:0]  iw2_q;
  logic [7:0]  iw3_q;
  logic [7:0]  iw4_q;
  logic [7:0]  mask_q;
  logic        sel_isr_q;
  logic        poll_q;
  logic        w_iw1;
  logic        w_pfw;
  logic        w_mcw;
  logic        w_a1;

  assign w_iw1 = wr_start & ~i_addr0 & i_data[IW1_MARK_BIT];                           // [RULE10]
  assign w_pfw = wr_start & ~i_addr0 & ~i_data[IW1_MARK_BIT] & ~i_data[MCW_MARK_BIT]; // [RULE10]
  assign w_mcw = wr_start & ~i_addr0 & ~i_data[IW1_MARK_BIT] & i_data[MCW_MARK_BIT];  // [RULE10]
  assign w_a1  = wr_start & i_addr0;

  // Init sequence and words, write only
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      init_q <= INIT_READY;
      iw1_q  <= BYTE_ZERO;
      iw2_q  <= BYTE_ZERO;
      iw3_q  <= BYTE_ZERO;
      iw4_q  <= BYTE_ZERO;
    end else if (w_iw1) begin
      iw1_q  <= i_data; // [RULE6]
      iw4_q  <= BYTE_ZERO;
      init_q <= INIT_WAIT2;
    end else if (w_a1) begin
      unique case (init_q) // [RULE11]
        INIT_WAIT2: begin
          iw2_q <= i_data;
          if (!iw1_q[IW1_SINGLE_BIT]) begin
            init_q <= INIT_WAIT3;
          end else if (iw1_q[IW1_NEED4_BIT]) begin
            init_q <= INIT_WAIT4;
          end else begin
            init_q <= INIT_READY;
          end
        end
        INIT_WAIT3: begin
          iw3_q  <= i_data;
          init_q <= iw1_q[IW1_NEED4_BIT] ? INIT_WAIT4 : INIT_READY;
        end
        INIT_WAIT4: begin
          iw4_q  <= i_data;
          init_q <= INIT_READY;
        end
        INIT_READY: begin
          init_q <= INIT_READY;
        end
      endcase
    end
  end

  // Mask register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || w_iw1) begin
      mask_q <= BYTE_ZERO;
    end else if (w_a1 && init_q == INIT_READY) begin
      mask_q <= i_data; // [RULE11] [RULE3]
    end
  end

  // Mode word: read select and polling phase
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || w_iw1) begin
      sel_isr_q <= 1'b0;
      poll_q    <= 1'b0;
    end else if (w_mcw) begin
      if (i_data[MCW_RDSEL_BIT]) begin
        sel_isr_q <= i_data[MCW_ISRSEL_BIT]; // [RULE8]
      end
      poll_q <= i_data[MCW_POLL_BIT]; // [RULE9]
    end else if (rd_end && !i_addr0) begin
      poll_q <= 1'b0;
    end
  end

  // ****************************************
  // Requests and priority
  // ****************************************
  logic [7:0] pending_q;
  logic [7:0] isr_q;
  logic       res_valid;
  logic [2:0] res_level;
  logic [2:0] lvl_q;
  logic       poll_take;
  logic [1:0] ack_cnt_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pending_q <= BYTE_ZERO;
    end else begin
      pending_q <= i_request_inputs; // [RULE4]
    end
  end

  priority_resolve u_resolve (
    .i_req   (pending_q),
    .i_mask  (mask_q),
    .i_isr   (isr_q),
    .o_valid (res_valid),
    .o_level (res_level)
  ); // [RULE7] [RULE3]

  assign poll_take = rd_end & ~i_addr0 & poll_q & res_valid;

  // In-service: set on first acknowledge or polled read, cleared by finish word
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || w_iw1) begin
      isr_q <= BYTE_ZERO;
    end else begin
      if (w_pfw && i_data[PFW_FINISH_BIT]) begin
        if (i_data[PFW_SPEC_BIT]) begin
          isr_q[i_data[2:0]] <= 1'b0;
        end else begin
          isr_q <= isr_q & (isr_q - 8'h01);
        end
      end
      if ((ack_start && ack_cnt_q == CNT_ZERO && res_valid) || poll_take) begin
        isr_q[res_level] <= 1'b1; // [RULE5]
      end
    end
  end

  // ****************************************
  // Acknowledge sequence
  // ****************************************
  logic       ack_busy_q;
  logic       vec_mode;
  logic       single;
  logic       master;
  logic       mine;
  logic [7:0] low_byte;
  logic [7:0] ack_byte;
  logic       ack_drive;

  assign vec_mode = iw4_q[IW4_VECTOR_BIT];
  assign single   = iw1_q[IW1_SINGLE_BIT];
  assign master   = ~single & i_slave_n;

  // Slave answers only its own number; master leaves slave levels alone
  assign mine = single
              | (master & ~iw3_q[lvl_q])
              | (~single & ~i_slave_n & (i_cascade_addr == iw3_q[2:0])); // [RULE13]

  assign low_byte = iw1_q[IW1_GAP4_BIT] ? {iw1_q[7:5], lvl_q, 2'b00}
                                         : {iw1_q[7:6], lvl_q, 3'b000};

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ack_cnt_q  <= CNT_ZERO;
      ack_busy_q <= 1'b0;
      lvl_q      <= 3'h0;
    end else begin
      if (ack_start && ack_cnt_q == CNT_ZERO) begin
        ack_busy_q <= 1'b1;
        lvl_q      <= res_level;
      end
      if (ack_end) begin
        if (ack_cnt_q == (vec_mode ? VECTOR_LAST : CALL_LAST)) begin // [RULE16]
          ack_cnt_q  <= CNT_ZERO;
          ack_busy_q <= 1'b0;
        end else begin
          ack_cnt_q <= ack_cnt_q + CNT_ONE;
        end
      end
    end
  end

  // Byte for the current pulse
  always_comb begin
    ack_byte  = BYTE_ZERO;
    ack_drive = 1'b0;
    if (ack_act && ack_busy_q) begin
      if (vec_mode) begin
        ack_byte  = {iw2_q[7:3], lvl_q};
        ack_drive = (ack_cnt_q == VECTOR_LAST) & mine; // [RULE14]
      end else if (ack_cnt_q == CNT_ZERO) begin
        ack_byte  = CALL_OPCODE;
        ack_drive = single | master; // [RULE14]
      end else begin
        ack_byte  = (ack_cnt_q == CNT_ONE) ? low_byte : iw2_q;
        ack_drive = mine; // [RULE14]
      end
    end
  end

  // ****************************************
  // Data port
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_data    <= BYTE_ZERO;
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= rd_act | ack_drive; // [RULE1]
      if (ack_drive) begin
        o_data <= ack_byte;
      end else if (i_addr0) begin
        o_data <= mask_q; // [RULE8]
      end else if (poll_q) begin
        o_data <= {res_valid, 4'h0, res_level}; // [RULE9]
      end else begin
        o_data <= sel_isr_q ? isr_q : pending_q; // [RULE8]
      end
    end
  end

  // ****************************************
  // Interrupt and cascade outputs
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_int <= 1'b0;
    end else begin
      o_int <= res_valid & ~ack_busy_q & ~wr_act & ~ack_act; // [RULE15]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cascade_addr    <= 3'h0;
      o_cascade_addr_oe <= 1'b0;
    end else begin
      o_cascade_addr    <= ack_busy_q ? lvl_q : 3'h0; // [RULE13]
      o_cascade_addr_oe <= master & ack_busy_q;       // [RULE13]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_port_float: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE1]
    (!rd_act && !ack_act) |=> !o_data_oe)
    else $error("data port driven outside read or acknowledge");

  a_strobe_clash: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE12]
    (!i_rd_n && !i_wr_n) |=> ($stable(mask_q) && $stable(iw1_q)))
    else $error("both strobes caused a transfer");

  a_mask_blocks: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE3]
    res_valid |-> !mask_q[res_level])
    else $error("masked level won priority");

  a_pending_map: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE4]
    ##1 pending_q == $past(i_request_inputs))
    else $error("pending register does not follow inputs");

  a_isr_set: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE5]
    (ack_start && ack_cnt_q == CNT_ZERO && res_valid && !w_iw1) |=> isr_q[$past(res_level)])
    else $error("in-service bit not set on acknowledge");

  a_mask_read: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE8]
    (rd_act && i_addr0 && !ack_drive) |=> (o_data_oe && o_data == $past(mask_q)))
    else $error("address 1 read not returning mask");

  a_iw1_start: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE10]
    w_iw1 |=> (init_q == INIT_WAIT2 && mask_q == BYTE_ZERO))
    else $error("first init word did not start sequence");

  a_mask_init: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE11]
    (w_a1 && init_q != INIT_READY) |=> $stable(mask_q))
    else $error("mask loaded during init sequence");

  a_int_write: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE15]
    wr_act[*2] |-> !o_int)
    else $error("interrupt stayed high during write");

  a_call_opcode: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE14]
    (ack_act && ack_busy_q && !vec_mode && ack_cnt_q == CNT_ZERO && single)
      |=> (o_data_oe && o_data == CALL_OPCODE))
    else $error("call opcode not sent on first acknowledge");

endmodule

// ### intc_pkg.sv
package intc_pkg;

  // ****************************************
  // Init word fields
  // ****************************************
  localparam int IW1_MARK_BIT   = 4;
  localparam int IW1_SINGLE_BIT = 1;
  localparam int IW1_NEED4_BIT  = 0;
  localparam int IW1_GAP4_BIT   = 2;
  localparam int IW4_VECTOR_BIT = 1;

  // ****************************************
  // Command word fields
  // ****************************************
  localparam int MCW_MARK_BIT   = 3;
  localparam int MCW_POLL_BIT   = 2;
  localparam int MCW_RDSEL_BIT  = 1;
  localparam int MCW_ISRSEL_BIT = 0;
  localparam int PFW_FINISH_BIT = 5;
  localparam int PFW_SPEC_BIT   = 6;

  // ****************************************
  // Constants
  // ****************************************
  localparam logic [7:0] CALL_OPCODE  = 8'hcd;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [1:0] CALL_LAST    = 2'h2;
  localparam logic [1:0] VECTOR_LAST  = 2'h1;
  localparam logic [1:0] CNT_ZERO     = 2'h0;
  localparam logic [1:0] CNT_ONE      = 2'h1;

  typedef enum logic [1:0] {
    INIT_READY = 2'b00,
    INIT_WAIT2 = 2'b01,
    INIT_WAIT3 = 2'b10,
    INIT_WAIT4 = 2'b11
  } init_state_e;

endpackage

// ### edge_detect.sv
`timescale 1ns/10ps
module edge_detect (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // Level in, edges out
  input  wire logic i_sig,
  output logic      o_rise,
  output logic      o_fall
);
  logic prev_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= i_sig;
    end
  end

  assign o_rise = i_sig & ~prev_q;
  assign o_fall = ~i_sig & prev_q;
endmodule

// ### priority_resolve.sv
`timescale 1ns/10ps
module priority_resolve (
  // Request state
  input  wire logic [7:0] i_req,
  input  wire logic [7:0] i_mask,
  input  wire logic [7:0] i_isr,
  // Winner
  output logic            o_valid,
  output logic [2:0]      o_level
);
  logic       found;
  logic       blocked;

  // Level 0 highest; a level in service blocks all levels below it but not itself
  always_comb begin
    found   = 1'b0;
    blocked = 1'b0;
    o_level = 3'h7;
    for (int i = 0; i < 8; i++) begin
      if (!found && !blocked && i_req[i] && !i_mask[i]) begin
        found   = 1'b1;
        o_level = 3'(i);
      end
      if (i_isr[i]) begin
        blocked = 1'b1;
      end
    end
    o_valid = found;
  end
endmodule

// ### host_cpu_model.sv
`timescale 1ns/10ps
// ****************************************
// Host processor bus model
// ****************************************
module host_cpu_model (
  // Clock
  input  wire logic       i_sys_clk,
  // From device
  input  wire logic [7:0] i_bus,
  input  wire logic       i_dev_oe,
  input  wire logic       i_int,
  // To device
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic            o_addr0,
  output logic [7:0]      o_wdata,
  output logic            o_ack_n
);
  initial begin
    o_cs_n  = 1'b1;
    o_rd_n  = 1'b1;
    o_wr_n  = 1'b1;
    o_addr0 = 1'b0;
    o_wdata = 8'h00;
    o_ack_n = 1'b1;
  end

  // Both strobes low only when a caller asks for it
  task automatic bus_write(input logic a0, input logic [7:0] d, input logic both,
                           output logic int_seen);
    @(posedge i_sys_clk);
    o_cs_n  <= 1'b0;
    o_wr_n  <= 1'b0;
    o_rd_n  <= ~both;
    o_addr0 <= a0;
    o_wdata <= d;
    repeat (3) @(posedge i_sys_clk);
    int_seen = i_int;
    o_cs_n  <= 1'b1;
    o_wr_n  <= 1'b1;
    o_rd_n  <= 1'b1;
    o_wdata <= ~d;
    repeat (2) @(posedge i_sys_clk);
  endtask

  task automatic bus_read(input logic a0, input logic sel, output logic [7:0] d,
                          output logic oe);
    @(posedge i_sys_clk);
    o_cs_n  <= ~sel;
    o_rd_n  <= 1'b0;
    o_addr0 <= a0;
    repeat (3) @(posedge i_sys_clk);
    d  = i_bus;
    oe = i_dev_oe;
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
  endtask

  // One low pulse per acknowledge byte
  task automatic ack_pulse(output logic [7:0] d, output logic oe);
    @(posedge i_sys_clk);
    o_ack_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    d  = i_bus;
    oe = i_dev_oe;
    o_ack_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
  endtask
endmodule

// ### interrupt_ctrl_host_port_test.sv
`timescale 1ns/10ps
module interrupt_ctrl_host_port_test
  import intc_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic        addr0;
  logic        ack_n;
  logic        int_out;
  logic        dev_oe;
  logic        cas_oe;
  logic [7:0]  wdata;
  logic [7:0]  dev_data;
  logic [7:0]  data_bus;
  logic [7:0]  req;
  logic [7:0]  mask;
  logic [7:0]  d;
  logic [2:0]  cas_in;
  logic [2:0]  cas_out;
  logic        oe;
  logic        s;
  logic        slave_n;
  int          num_errors;
  int          num_checks;
  integer      seed;

  assign data_bus = dev_oe ? dev_data : wdata;

  // ****************************************
  // Clock, device and host
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  intc_host_port u_dut (
    .i_sys_clk           (clk),
    .i_rst               (rst),
    .i_cs_n              (cs_n),
    .i_rd_n              (rd_n),
    .i_wr_n              (wr_n),
    .i_addr0             (addr0),
    .i_data              (data_bus),
    .o_data              (dev_data),
    .o_data_oe           (dev_oe),
    .i_irq_acknowledge_n (ack_n),
    .o_int               (int_out),
    .i_request_inputs    (req),
    .i_slave_n           (slave_n),
    .i_cascade_addr      (cas_in),
    .o_cascade_addr      (cas_out),
    .o_cascade_addr_oe   (cas_oe)
  );

  host_cpu_model u_host (
    .i_sys_clk (clk),
    .i_bus     (data_bus),
    .i_dev_oe  (dev_oe),
    .i_int     (int_out),
    .o_cs_n    (cs_n),
    .o_rd_n    (rd_n),
    .o_wr_n    (wr_n),
    .o_addr0   (addr0),
    .o_wdata   (wdata),
    .o_ack_n   (ack_n)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [7:0] vec_byte(input logic [7:0] base, input logic [2:0] lvl);
    return {base[7:3], lvl};
  endfunction

  task automatic wr(input logic a0, input logic [7:0] v);
    u_host.bus_write(a0, v, 1'b0, s);
  endtask

  task automatic rd(input logic a0, output logic [7:0] v);
    u_host.bus_read(a0, 1'b1, v, oe);
    check({7'h00, oe}, 8'h01);
    check({7'h00, dev_oe}, 8'h00);
  endtask

  task automatic wait_int(input logic exp);
    repeat (4) @(posedge clk);
    check({7'h00, int_out}, {7'h00, exp});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 32'hf8de;
    num_errors = 0;
    num_checks = 0;
    rst = 1'b1;
    req = 8'h00;
    cas_in = 3'h0;
    slave_n = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({6'h00, int_out, dev_oe}, 8'h00);
    wr(1'b0, 8'h13);
    wr(1'b1, 8'hc8);
    wr(1'b1, 8'h02);
    for (int i = 0; i < 6; i++) begin
      mask = 8'($random(seed));
      cas_in <= 3'($random(seed));
      wr(1'b1, mask);
      rd(1'b1, d);
      check(d, mask);
    end
    u_host.bus_write(1'b1, ~mask, 1'b1, s);
    rd(1'b1, d);
    check(d, mask);
    u_host.bus_read(1'b1, 1'b0, d, oe);
    check({7'h00, oe}, 8'h00);
    wr(1'b0, 8'h0a);
    wr(1'b1, 8'hff);
    for (int i = 0; i < 6; i++) begin
      req <= 8'($random(seed));
      repeat (4) @(posedge clk);
      rd(1'b0, d);
      check(d, req);
      check({7'h00, int_out}, 8'h00);
    end
    req <= 8'h28;
    wr(1'b1, 8'h00);
    wait_int(1'b1);
    for (int i = 0; i < 2; i++) begin
      u_host.ack_pulse(d, oe);
      check({7'h00, oe}, 8'(i));
    end
    check(d, vec_byte(8'hc8, 3'd3));
    req <= 8'h20;
    wait_int(1'b0);
    wr(1'b0, 8'h0b);
    rd(1'b0, d);
    check(d, 8'h08);
    wr(1'b0, 8'h20);
    wait_int(1'b1);
    u_host.bus_write(1'b1, 8'h00, 1'b0, s);
    check({7'h00, s}, 8'h00);
    wr(1'b0, 8'h0c);
    rd(1'b0, d);
    check(d, {5'h10, 3'd5});
    wr(1'b0, 8'h0b);
    rd(1'b0, d);
    check(d, 8'h20);
    wr(1'b0, 8'h20);
    req <= 8'h00;
    wr(1'b0, 8'hb7);
    wr(1'b1, 8'h5a);
    wr(1'b1, 8'h00);
    wr(1'b1, 8'h00);
    req <= 8'h04;
    wait_int(1'b1);
    u_host.ack_pulse(d, oe);
    check(d, CALL_OPCODE);
    u_host.ack_pulse(d, oe);
    check(d, {3'b101, 3'd2, 2'b00});
    u_host.ack_pulse(d, oe);
    check(d, 8'h5a);
    check({7'h00, dev_oe}, 8'h00);
    check({7'h00, cas_oe}, 8'h00);
    // ****************************************
    // Cascade master, then slave
    // ****************************************
    req <= 8'h00;
    wr(1'b0, 8'h11);
    wr(1'b1, 8'h40);
    wr(1'b1, 8'h04);
    wr(1'b1, 8'h02);
    wr(1'b1, 8'h00);
    req <= 8'h04;
    wait_int(1'b1);
    u_host.ack_pulse(d, oe);
    check({5'h00, cas_out}, 8'h02);
    check({7'h00, cas_oe}, 8'h01);
    u_host.ack_pulse(d, oe);
    check({7'h00, oe}, 8'h00);
    check({7'h00, cas_oe}, 8'h00);
    req <= 8'h00;
    slave_n <= 1'b0;
    cas_in <= 3'h3;
    wr(1'b0, 8'h11);
    wr(1'b1, 8'h48);
    wr(1'b1, 8'h03);
    wr(1'b1, 8'h02);
    wr(1'b1, 8'h00);
    req <= 8'h10;
    wait_int(1'b1);
    repeat (2) u_host.ack_pulse(d, oe);
    check({7'h00, oe}, 8'h01);
    check(d, vec_byte(8'h48, 3'd4));
    check({7'h00, cas_oe}, 8'h00);
    wr(1'b0, 8'h0b);
    rd(1'b0, d);
    check(d, 8'h10);
    wr(1'b0, 8'h64);
    rd(1'b0, d);
    check(d, 8'h00);
    cas_in <= 3'h5;
    wait_int(1'b1);
    repeat (2) u_host.ack_pulse(d, oe);
    check({7'h00, oe}, 8'h00);
    end_of_test();
  end

  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule
